// ===== pkg/pcc_pkg.sv
// register map, field layouts and reset values of the port and comparator block
`default_nettype none
package pcc_pkg;
  // byte addresses on the register bus
  localparam logic [7:0] ADDR_PORT_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_PORT2_MODE  = 8'h04;
  localparam logic [7:0] ADDR_PORT3_MODE  = 8'h08;
  localparam logic [7:0] ADDR_PORT2_DATA  = 8'h0c;
  localparam logic [7:0] ADDR_PORT3_DATA  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_REQUEST = 8'h14;
  localparam logic [7:0] ADDR_STOP_RECOV  = 8'h18;
  localparam logic [7:0] ADDR_WDT_MODE    = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h24;
  localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h28;

  // reset values
  localparam logic [7:0] PORT_CONFIG_RST = 8'h00;
  localparam logic [7:0] PORT2_MODE_RST  = 8'hff;
  localparam logic [7:0] PORT3_MODE_RST  = 8'h00;
  localparam logic [7:0] WDT_MODE_RST    = 8'h00;

  // field positions
  localparam int unsigned EDGE_SEL_LSB   = 6;
  localparam int unsigned RECOV_SEL_LSB  = 2;
  localparam int unsigned RECOV_FLAG_BIT = 7;
  localparam int unsigned IRQ_IN2        = 0;
  localparam int unsigned IRQ_CMPREF     = 1;
  localparam int unsigned IRQ_IN1        = 2;
  localparam int unsigned P3_IN_LSB      = 1;
  localparam int unsigned P3_OUT_LSB     = 4;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       oscStdDrive;
    logic       port3StdDrive;
    logic       port2StdDrive;
    logic [3:0] unused;
    logic       cmpRoute;
  } pcc_port_config_t;

  typedef struct packed {
    logic [4:0] unused;
    logic       timerOutEn;
    logic       analogMode;
    logic       port2PushPull;
  } pcc_port3_mode_t;
endpackage
`default_nettype wire

// ===== core/pcc_port_comparator_config.sv
// port, comparator and port configuration logic behind an axi4-lite slave
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pcc_port_comparator_config
  import pcc_pkg::*;
(
  // clock and resets
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        wdtResetReq,
  input  wire logic        stopRecoveryReq,
  // axi4-lite register slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // bidirectional port pins
  input  wire logic [7:0]  port2In,
  output logic [7:0]       port2Out,
  output logic [7:0]       port2OutEn_n,
  // six-line port pins, index 0 is line 1 or line 4
  input  wire logic [2:0]  port3In,
  output logic [2:0]       port3Out,
  // analog comparator results
  input  wire logic [1:0]  cmpResult,
  // counter/timer hookup
  output logic             timer1Input,
  input  wire logic        timer1Output,
  // drive strength controls
  output logic             port2StdDrive,
  output logic             port3StdDrive,
  output logic             oscStdDrive,
  // interrupt
  output logic             irq
);

  logic [12:0]      pinMeta_ff;
  logic [12:0]      pinSync_ff;
  logic [7:0]       port2Sync;
  logic [2:0]       port3Sync;
  logic [1:0]       cmpSync;
  pcc_port_config_t portConfig_ff;
  pcc_port3_mode_t  port3Mode_ff;
  logic [7:0]       port2Dir_ff;
  logic [7:0]       port2Data_ff;
  logic [2:0]       port3Data_ff;
  logic [1:0]       edgeSel_ff;
  logic [2:0]       recovSel_ff;
  logic             recovFlag_ff;
  logic [7:0]       wdtMode_ff;
  logic [2:0]       irqStatus_ff;
  logic [2:0]       irqEnable_ff;
  logic [2:0]       lvlPrev_ff;
  logic [2:0]       port3Out_ff;
  logic [2:0]       nxt_port3Out;
  logic [7:0]       port2Out_ff;
  logic [7:0]       port2OutEn_n_ff;
  logic             awHeld_ff;
  logic             wHeld_ff;
  logic [7:0]       wrAddr_ff;
  logic [7:0]       wrByte_ff;
  logic             wrStrb_ff;
  logic             bValid_ff;
  logic [1:0]       bResp_ff;
  logic             rValid_ff;
  logic [31:0]      rData_ff;
  logic [1:0]       rResp_ff;
  logic [7:0]       rdByte;
  logic             rdKnown;
  logic             wrEn;
  logic             anyReset;
  logic             recovSrc;
  logic [2:0]       lvl;
  logic [2:0]       irqEvent;
  logic [2:0]       clrMask;

  function automatic logic addrKnown(input logic [7:0] a);
    addrKnown = (a <= ADDR_IRQ_ENABLE) && (a[1:0] == 2'h0);
  endfunction

  assign anyReset = wdtResetReq | stopRecoveryReq;
  assign wrEn     = awHeld_ff & wHeld_ff & wrStrb_ff;

  // two-flop synchronisers for every pin and comparator result
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
    end
    else
    begin
      pinMeta_ff <= {cmpResult, port3In, port2In};
      pinSync_ff <= pinMeta_ff;
    end
  end

  assign port2Sync   = pinSync_ff[7:0];
  assign port3Sync   = pinSync_ff[10:8];
  assign cmpSync     = pinSync_ff[12:11];
  assign timer1Input = port3Sync[0];

  // selected stop-recovery source, active low
  always_comb
  begin
    unique case (recovSel_ff)
      3'h2:    recovSrc = port3Sync[0];
      3'h3:    recovSrc = port3Sync[1];
      3'h4:    recovSrc = port3Sync[2];
      3'h5:    recovSrc = port2Sync[7];
      3'h6:    recovSrc = ~|port2Sync[3:0];
      3'h7:    recovSrc = ~|port2Sync;
      default: recovSrc = 1'b1;
    endcase
  end

  // input levels as seen by interrupts and data reads
  assign lvl[0] = port3Mode_ff.analogMode ? cmpSync[0] : port3Sync[0];
  assign lvl[1] = port3Mode_ff.analogMode ? cmpSync[1] : port3Sync[1];
  assign lvl[2] = port3Mode_ff.analogMode ? recovSrc : port3Sync[2];

  // edge detection per input line; reset matches the synchroniser, no false edge
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      lvlPrev_ff <= '0;
    else
      lvlPrev_ff <= lvl;
  end

  assign irqEvent[IRQ_IN1] = (lvl[0] & ~lvlPrev_ff[0] & edgeSel_ff[1]) |
                             (~lvl[0] & lvlPrev_ff[0] & (~edgeSel_ff[1] | edgeSel_ff[0]));
  assign irqEvent[IRQ_IN2] = (lvl[1] & ~lvlPrev_ff[1] & edgeSel_ff[0]) |
                             (~lvl[1] & lvlPrev_ff[1] & (~edgeSel_ff[0] | edgeSel_ff[1]));
  assign irqEvent[IRQ_CMPREF] = ~lvl[2] & lvlPrev_ff[2];

  // port configuration register, write-only
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      portConfig_ff <= PORT_CONFIG_RST;
    else if (anyReset)
      portConfig_ff <= PORT_CONFIG_RST;
    else if (wrEn && wrAddr_ff == ADDR_PORT_CONFIG)
      portConfig_ff <= wrByte_ff;
  end

  assign port2StdDrive = portConfig_ff.port2StdDrive;
  assign port3StdDrive = portConfig_ff.port3StdDrive;
  assign oscStdDrive   = portConfig_ff.oscStdDrive;

  // mode registers survive a stop recovery
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      port2Dir_ff  <= PORT2_MODE_RST;
      port3Mode_ff <= PORT3_MODE_RST;
      recovSel_ff  <= '0;
      wdtMode_ff   <= WDT_MODE_RST;
    end
    else if (wdtResetReq)
    begin
      port2Dir_ff  <= PORT2_MODE_RST;
      port3Mode_ff <= PORT3_MODE_RST;
      recovSel_ff  <= '0;
      wdtMode_ff   <= WDT_MODE_RST;
    end
    else if (wrEn && !stopRecoveryReq)
    begin
      if (wrAddr_ff == ADDR_PORT2_MODE)
        port2Dir_ff <= wrByte_ff;
      if (wrAddr_ff == ADDR_PORT3_MODE)
        port3Mode_ff <= wrByte_ff;
      if (wrAddr_ff == ADDR_STOP_RECOV)
        recovSel_ff <= wrByte_ff[RECOV_SEL_LSB +: 3];
      if (wrAddr_ff == ADDR_WDT_MODE)
        wdtMode_ff <= wrByte_ff;
    end
  end

  // recovery flag, cleared only at power-on
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      recovFlag_ff <= 1'b0;
    else if (stopRecoveryReq)
      recovFlag_ff <= 1'b1;
  end

  // data latches and edge select
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      port2Data_ff <= '0;
      port3Data_ff <= '0;
      edgeSel_ff   <= '0;
    end
    else if (anyReset)
    begin
      port2Data_ff <= '0;
      port3Data_ff <= '0;
      edgeSel_ff   <= '0;
    end
    else if (wrEn)
    begin
      if (wrAddr_ff == ADDR_PORT2_DATA)
        port2Data_ff <= wrByte_ff;
      if (wrAddr_ff == ADDR_PORT3_DATA)
        port3Data_ff <= wrByte_ff[P3_OUT_LSB +: 3];
      if (wrAddr_ff == ADDR_IRQ_REQUEST)
        edgeSel_ff <= wrByte_ff[EDGE_SEL_LSB +: 2];
    end
  end

  // six-line port outputs, always push-pull
  always_comb
  begin
    nxt_port3Out = port3Data_ff;
    if (portConfig_ff.cmpRoute)
      nxt_port3Out[1:0] = cmpSync;
    if (port3Mode_ff.timerOutEn)
      nxt_port3Out[2] = timer1Output;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      port3Out_ff <= '0;
    else
      port3Out_ff <= nxt_port3Out;
  end

  assign port3Out = port3Out_ff;

  // per-line drive of the bidirectional port; dir bit 1 means input
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_port2
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          port2Out_ff[gi]     <= 1'b0;
          port2OutEn_n_ff[gi] <= 1'b1;
        end
        else
        begin
          port2Out_ff[gi]     <= port2Data_ff[gi];
          port2OutEn_n_ff[gi] <= port2Dir_ff[gi] |
                                 (~port3Mode_ff.port2PushPull & port2Data_ff[gi]);
        end
      end
    end
  endgenerate

  assign port2Out     = port2Out_ff;
  assign port2OutEn_n = port2OutEn_n_ff;

  // sticky interrupt status; a new event wins over a clear
  assign clrMask = (wrEn && wrAddr_ff == ADDR_IRQ_CLEAR) ? wrByte_ff[2:0] : 3'h0;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      irqStatus_ff <= '0;
      irqEnable_ff <= '0;
    end
    else if (anyReset)
    begin
      irqStatus_ff <= '0;
      irqEnable_ff <= '0;
    end
    else
    begin
      irqStatus_ff <= (irqStatus_ff & ~clrMask) | irqEvent;
      if (wrEn && wrAddr_ff == ADDR_IRQ_ENABLE)
        irqEnable_ff <= wrByte_ff[2:0];
    end
  end

  assign irq = |(irqStatus_ff & irqEnable_ff);

  // write channel: address and data in either order, response after both
  assign s_axi_awready = ~awHeld_ff & ~bValid_ff;
  assign s_axi_wready  = ~wHeld_ff & ~bValid_ff;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      wrAddr_ff <= '0;
      wrByte_ff <= '0;
      wrStrb_ff <= 1'b0;
      bValid_ff <= 1'b0;
      bResp_ff  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_ff <= 1'b1;
        wrAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_ff  <= 1'b1;
        wrByte_ff <= s_axi_wdata[7:0];
        wrStrb_ff <= s_axi_wstrb[0];
      end
      if (awHeld_ff && wHeld_ff)
      begin
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff  <= addrKnown(wrAddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bValid_ff && s_axi_bready)
        bValid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp  = bResp_ff;

  // read data mux
  always_comb
  begin
    rdByte  = 8'h00;
    rdKnown = addrKnown(s_axi_araddr);
    case (s_axi_araddr)
      ADDR_PORT2_MODE:  rdByte = port2Dir_ff;
      ADDR_PORT3_MODE:  rdByte = port3Mode_ff;
      ADDR_PORT2_DATA:  rdByte = port2Sync;
      ADDR_PORT3_DATA:  rdByte = {1'b0, port3Data_ff, lvl, 1'b0};
      ADDR_IRQ_REQUEST: rdByte = {edgeSel_ff, 6'h00};
      ADDR_STOP_RECOV:  rdByte = {recovFlag_ff, 7'h00};
      ADDR_WDT_MODE:    rdByte = wdtMode_ff;
      ADDR_IRQ_STATUS:  rdByte = {5'h00, irqStatus_ff};
      ADDR_IRQ_ENABLE:  rdByte = {5'h00, irqEnable_ff};
      default:          rdByte = 8'h00;
    endcase
  end

  assign s_axi_arready = ~rValid_ff;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rValid_ff <= 1'b0;
      rData_ff  <= '0;
      rResp_ff  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rValid_ff <= 1'b1;
      rData_ff  <= {24'h000000, rdByte};
      rResp_ff  <= rdKnown ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rValid_ff && s_axi_rready)
      rValid_ff <= 1'b0;
  end

  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata  = rData_ff;
  assign s_axi_rresp  = rResp_ff;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_cfgWrite;
    wrEn && wrAddr_ff == ADDR_PORT_CONFIG && !anyReset;
  endsequence

  sequence s_readOf(logic [7:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence

  a_cfg_reset_value: assert property (anyReset |=> portConfig_ff == PORT_CONFIG_RST)
    else $error("port config not reset");
  a_cfg_write_drive: assert property (s_cfgWrite |=> {port3StdDrive, port2StdDrive} == $past(wrByte_ff[6:5]))
    else $error("port drive does not follow config write");
  a_osc_drive: assert property (s_cfgWrite |=> oscStdDrive == $past(wrByte_ff[7]))
    else $error("oscillator drive does not follow config write");
  a_cfg_read_zero: assert property (s_readOf(ADDR_PORT_CONFIG) |=> s_axi_rvalid && s_axi_rdata == 32'h0)
    else $error("config register read not zero");
  a_modes_kept: assert property (stopRecoveryReq && !wdtResetReq |=>
      $stable(port3Mode_ff) && $stable(port2Dir_ff) && $stable(recovSel_ff) && $stable(wdtMode_ff))
    else $error("mode register changed on stop recovery");
  a_cmp_route: assert property (portConfig_ff.cmpRoute |=> port3Out[1:0] == $past(cmpSync))
    else $error("comparator not routed to outputs");
  a_timer_out: assert property (port3Mode_ff.timerOutEn |=> port3Out[2] == $past(timer1Output))
    else $error("timer output not on line six");
  a_rise_in1: assert property (lvl[0] && !lvlPrev_ff[0] && edgeSel_ff == 2'h2 && !anyReset |=> irqStatus_ff[IRQ_IN1])
    else $error("rising edge on in1 lost");
  a_fall_ignored: assert property (!lvl[1] && lvlPrev_ff[1] && edgeSel_ff == 2'h1 && !irqStatus_ff[IRQ_IN2]
      |=> !irqStatus_ff[IRQ_IN2])
    else $error("falling edge on in2 taken in rising mode");
  a_analog_read: assert property (s_readOf(ADDR_PORT3_DATA) ##0 port3Mode_ff.analogMode
      |=> s_axi_rdata[2:1] == $past(cmpSync))
    else $error("analog read not comparator result");
  a_cmpref_src: assert property (port3Mode_ff.analogMode && !recovSrc && lvlPrev_ff[2] && !anyReset
      |=> irqStatus_ff[IRQ_CMPREF])
    else $error("recovery source did not raise reference interrupt");
  a_open_drain: assert property (!port3Mode_ff.port2PushPull && $stable(port3Mode_ff)
      |-> ((~port2OutEn_n) & port2Out) == 8'h00)
    else $error("open-drain line driven high");
  a_write_resp: assert property (awHeld_ff && wHeld_ff |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");
endmodule
`default_nettype wire

// ===== tb/pcc_board_model.sv
// board side: pad resolution of the bidirectional port and the two comparators
`timescale 1ns/1ps
`default_nettype none
module pcc_board_model
(
  // bidirectional pads
  input  wire logic [7:0] port2Out,
  input  wire logic [7:0] port2OutEn_n,
  input  wire logic [7:0] boardLvl,
  output logic      [7:0] port2In,
  // analog levels
  input  wire logic [7:0] ain1,
  input  wire logic [7:0] ain2,
  input  wire logic [7:0] aref,
  output logic      [1:0] cmpResult
);
  // released lines follow the board driver or pull-up
  assign port2In   = (port2OutEn_n & boardLvl) | (~port2OutEn_n & port2Out);
  assign cmpResult = {ain2 > aref, ain1 > aref};
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench of the port and comparator block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pcc_pkg::*;
  logic        clk_sys = 1'h0;
  logic        resetn = 1'h0;
  logic        wdtResetReq = 1'h0;
  logic        stopRecoveryReq = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'h0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'h0;
  logic [7:0]  port2In;
  logic [7:0]  port2Out;
  logic [7:0]  port2OutEn_n;
  logic [2:0]  port3In = 3'h4;
  logic [2:0]  port3Out;
  logic [1:0]  cmpResult;
  logic        timer1Input;
  logic        timer1Output = 1'h0;
  logic        port2StdDrive;
  logic        port3StdDrive;
  logic        oscStdDrive;
  logic        irq;
  logic [7:0]  boardLvl = 8'h00;
  logic [7:0]  ain1 = 8'h00;
  logic [7:0]  ain2 = 8'h00;
  logic [7:0]  aref = 8'h00;
  int          seed = 32'h75de;
  int          fail_count = 0;
  int          checks = 0;

  // one bench cycle per system clock tick; the low-emission rate limit is the clock source's
  always #4 clk_sys = ~clk_sys;

  pcc_port_comparator_config dut (.clk_sys, .resetn, .wdtResetReq, .stopRecoveryReq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port2In, .port2Out,
    .port2OutEn_n, .port3In, .port3Out, .cmpResult, .timer1Input, .timer1Output, .port2StdDrive,
    .port3StdDrive, .oscStdDrive, .irq);

  pcc_board_model board (.port2Out, .port2OutEn_n, .boardLvl, .port2In, .ain1, .ain2, .aref, .cmpResult);

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tmo();
    fail_count++;
    $display("Error at %0t: bus wait ran out", $time);
    summarize();
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1 && n < 40);
    if (n >= 40) tmo();
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1 && n < 40);
    if (n >= 40) tmo();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d & m, e);
    chk(r, RESP_OKAY);
  endtask

  function automatic logic [7:0] en2(input logic [7:0] dir, input logic [7:0] dat, input bit pp);
    return pp ? dir : (dir | dat);
  endfunction

  function automatic logic [2:0] edges(input logic [1:0] code, input bit rise);
    return {code == 2'h3 || code[1] == rise, 1'h0, code == 2'h3 || code[0] == rise};
  endfunction

  function automatic logic recovExp(input logic [2:0] sel, input logic [2:0] p3, input logic [7:0] p2);
    case (sel)
      3'h2:    return p3[0];
      3'h3:    return p3[1];
      3'h4:    return p3[2];
      3'h5:    return p2[7];
      3'h6:    return ~|p2[3:0];
      3'h7:    return ~|p2;
      default: return 1'h1;
    endcase
  endfunction

  initial
  begin
    logic [7:0]  cfg, dir, dat, brd, e8;
    logic [2:0]  m, ev;
    logic [1:0]  cmp, r;
    logic [31:0] d;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'h1;
    chk(port2OutEn_n, 8'hff);
    chk({oscStdDrive, port3StdDrive, port2StdDrive}, 3'h0);
    repeat (4)
    begin
      cfg = 8'($random(seed));
      wr(ADDR_PORT_CONFIG, cfg, RESP_OKAY);
      pause(2);
      chk({oscStdDrive, port3StdDrive, port2StdDrive}, cfg[7:5]);
      rc(ADDR_PORT_CONFIG, 32'hff, 32'h0);
    end
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_PORT_CONFIG, 8'he1, RESP_OKAY);
      if (i == 0) wdtResetReq <= 1'h1; else stopRecoveryReq <= 1'h1;
      @(posedge clk_sys);
      wdtResetReq <= 1'h0;
      stopRecoveryReq <= 1'h0;
      pause(2);
      chk({oscStdDrive, port3StdDrive, port2StdDrive}, 3'h0);
    end
    $display("test config done");
    for (int i = 0; i < 6; i++)
    begin
      dir = 8'($random(seed));
      dat = 8'($random(seed));
      brd = 8'($random(seed));
      boardLvl <= brd;
      wr(ADDR_PORT3_MODE, {7'h0, i[0]}, RESP_OKAY);
      wr(ADDR_PORT2_MODE, dir, RESP_OKAY);
      wr(ADDR_PORT2_DATA, dat, RESP_OKAY);
      pause(4);
      e8 = en2(dir, dat, i[0]);
      chk(port2OutEn_n, e8);
      rc(ADDR_PORT2_DATA, 32'hff, (e8 & brd) | (~e8 & dat));
    end
    $display("test bidir done");
    for (int i = 0; i < 8; i++)
    begin
      m = i[2:0];
      dat = 8'($random(seed));
      ain1 <= 8'($random(seed));
      ain2 <= 8'($random(seed));
      aref <= 8'($random(seed));
      port3In <= dat[2:0];
      timer1Output <= dat[3];
      wr(ADDR_PORT3_MODE, {5'h0, m[1:0], 1'h1}, RESP_OKAY);
      wr(ADDR_PORT_CONFIG, {7'h0, m[2]}, RESP_OKAY);
      wr(ADDR_PORT3_DATA, {1'h0, dat[6:4], 4'h0}, RESP_OKAY);
      pause(4);
      cmp = {ain2 > aref, ain1 > aref};
      chk(port3Out, {m[1] ? dat[3] : dat[6], m[2] ? cmp : dat[5:4]});
      chk(timer1Input, dat[0]);
      rc(ADDR_PORT3_DATA, 32'h7e, {dat[6:4], m[0] ? {1'h1, cmp} : dat[2:0], 1'h0});
    end
    $display("test port3 done");
    port3In <= 3'h4;
    wr(ADDR_PORT3_MODE, 8'h01, RESP_OKAY);
    wr(ADDR_IRQ_ENABLE, 8'h05, RESP_OKAY);
    pause(5);
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_IRQ_REQUEST, {c[1:0], 6'h0}, RESP_OKAY);
      for (int e = 1; e >= 0; e--)
      begin
        wr(ADDR_IRQ_CLEAR, 8'hff, RESP_OKAY);
        port3In <= {1'h1, e[0], e[0]};
        pause(5);
        ev = edges(c[1:0], e[0]);
        rc(ADDR_IRQ_STATUS, 32'h07, ev);
        chk(irq, |ev);
      end
    end
    wr(ADDR_IRQ_ENABLE, 8'h00, RESP_OKAY);
    pause(1);
    chk(irq, 1'h0);
    wr(ADDR_IRQ_ENABLE, 8'h05, RESP_OKAY);
    pause(1);
    chk(irq, 1'h1);
    wr(ADDR_IRQ_CLEAR, 8'hff, RESP_OKAY);
    pause(1);
    chk(irq, 1'h0);
    $display("test interrupt done");
    wr(ADDR_PORT2_MODE, 8'h5a, RESP_OKAY);
    wr(ADDR_PORT3_MODE, 8'h03, RESP_OKAY);
    wr(ADDR_WDT_MODE, 8'h18, RESP_OKAY);
    wr(ADDR_STOP_RECOV, 8'h08, RESP_OKAY);
    port3In <= 3'h1;
    pause(5);
    rc(ADDR_PORT3_DATA, 32'h08, 32'h08);
    wr(ADDR_IRQ_CLEAR, 8'hff, RESP_OKAY);
    port3In <= 3'h0;
    pause(5);
    rc(ADDR_IRQ_STATUS, 32'h02, 32'h02);
    // every recovery source select, seen on the in3 data bit in analog mode
    for (int s = 0; s < 8; s++)
    begin
      dat = 8'($random(seed));
      port3In <= dat[2:0];
      wr(ADDR_STOP_RECOV, {3'h0, s[2:0], 2'h0}, RESP_OKAY);
      pause(4);
      rc(ADDR_PORT3_DATA, 32'h08, {recovExp(s[2:0], dat[2:0], port2In), 3'h0});
    end
    stopRecoveryReq <= 1'h1;
    @(posedge clk_sys);
    stopRecoveryReq <= 1'h0;
    pause(2);
    rc(ADDR_PORT2_MODE, 32'hff, 32'h5a);
    rc(ADDR_PORT3_MODE, 32'h07, 32'h03);
    rc(ADDR_WDT_MODE, 32'h18, 32'h18);
    rc(ADDR_STOP_RECOV, 32'h80, 32'h80);
    wdtResetReq <= 1'h1;
    @(posedge clk_sys);
    wdtResetReq <= 1'h0;
    pause(2);
    rc(ADDR_PORT2_MODE, 32'hff, 32'hff);
    $display("test recovery done");
    wr(8'h2c, 8'h00, RESP_SLVERR);
    wr(8'h02, 8'h00, RESP_SLVERR);
    rd(8'h30, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(ADDR_PORT2_MODE, 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rc(ADDR_PORT2_MODE, 32'hff, 32'hff);
    wr(ADDR_PORT_CONFIG, 8'he0, RESP_OKAY);
    resetn <= 1'h0;
    pause(2);
    resetn <= 1'h1;
    chk({oscStdDrive, port3StdDrive, port2StdDrive}, 3'h0);
    rc(ADDR_STOP_RECOV, 32'h80, 32'h00);
    $display("test bus and reset done");
    summarize();
  end
endmodule
`default_nettype wire
